// file: pkg/scg_pkg.sv
// ---------------------------------------------------------------------------
// Register map, field layout and engine constants of the safety, CRC and
// gain register slice.
// ---------------------------------------------------------------------------
package scg_pkg;

  // -------------------------------------------------------------------------
  // Register indices; the byte address of a register is four times its index.
  // -------------------------------------------------------------------------
  localparam logic [9:0] IDX_SAFETY_FAULT_CLEAR   = 10'h080;
  localparam logic [9:0] IDX_SAFETY_FAULT_MASK    = 10'h081;
  localparam logic [9:0] IDX_SAFETY_FAULT_SUMMARY = 10'h082;
  localparam logic [9:0] IDX_SAFETY_ERROR_CODE    = 10'h083;
  localparam logic [9:0] IDX_CRC_RESULT_LOW       = 10'h084;
  localparam logic [9:0] IDX_CRC_RESULT_HIGH      = 10'h085;
  localparam logic [9:0] IDX_MAP_CHECK_START      = 10'h086;
  localparam logic [9:0] IDX_MAP_CHECK_DONE       = 10'h087;
  localparam logic [9:0] IDX_MAP_CHECK_LOW        = 10'h088;
  localparam logic [9:0] IDX_MAP_CHECK_HIGH       = 10'h089;
  localparam logic [9:0] IDX_FRONT_AMP_GAIN       = 10'h100;
  localparam logic [9:0] IDX_VARIABLE_AMP_GAIN    = 10'h101;

  // -------------------------------------------------------------------------
  // Reset values.
  // -------------------------------------------------------------------------
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [5:0]  RST_ERR   = 6'h00;
  localparam logic [7:0]  RST_GAIN  = 8'h00;

  // -------------------------------------------------------------------------
  // Safety error code bit positions.
  // -------------------------------------------------------------------------
  localparam int BIT_CRC_ERROR  = 0;
  localparam int BIT_HOT        = 1;
  localparam int BIT_REFERENCE  = 2;
  localparam int BIT_POS_BIAS   = 3;
  localparam int BIT_NEG_BIAS   = 4;
  localparam int BIT_CLOCK_LOSS = 5;
  localparam int ERR_WIDTH      = 6;

  // -------------------------------------------------------------------------
  // Register map check engine: CRC-16 polynomial, seed and covered words.
  // -------------------------------------------------------------------------
  localparam logic [15:0] MAP_CRC_POLY  = 16'h1021;
  localparam logic [15:0] MAP_CRC_SEED  = 16'hFFFF;
  localparam logic [2:0]  MAP_CRC_WORDS = 3'h4;

  // Engine states, Gray coded along idle, run, latch.
  typedef enum logic [1:0] {
    SCG_IDLE  = 2'b00,
    SCG_RUN   = 2'b01,
    SCG_LATCH = 2'b11
  } scg_state_type;

endpackage

// file: hdl/scg_regs.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps

// Contract
// - Read-only six-flag error code, clock loss at bit five, CRC error at bit zero.
// - Error code register resets to zero, all flags reading no error.
// - Sixteen-bit CRC result read as low byte then high byte registers.
// - Writing one to start bit 0 launches a register map CRC when the engine is idle; resets to zero.
// - Done bit reads one when map CRC finished, zero otherwise; resets zero.
// - Map CRC result read as low byte then high byte, both reset zero.
// - Front gain register holds four 2-bit fields, channel 4 on top.
// - Front gain codes 00..11 mean gain 2, 4, 8, 16; reset 00.
// - Variable gain register has four 2-bit fields in the same channel order.
// - Variable gain codes 00..11 mean gain 1.4, 2.8, 5.6, 11.2; reset 00.
// - Mask register bit per error source keeps that error from being reported.
// - Summary bit reads one while any unmasked error is present.
module scg_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        clock_loss_fault,
  input  wire logic        neg_bias_fault,
  input  wire logic        pos_bias_fault,
  input  wire logic        reference_fault,
  input  wire logic        hot_fault,
  input  wire logic        crc_error_fault,
  input  wire logic [15:0] crc_value_in,
  output logic             safety_fault_summary,
  output logic             map_check_busy,
  output logic             map_check_done,
  output logic      [7:0]  front_amp_gain,
  output logic      [19:0] front_amp_gain_mult,
  output logic      [7:0]  variable_amp_gain,
  output logic      [27:0] variable_amp_gain_tenths
);

  // -------------------------------------------------------------------------
  // Helper functions.
  // -------------------------------------------------------------------------

  // Folds one 16-bit word, most significant bit first, into the CRC.
  function automatic logic [15:0] crc16_word(input logic [15:0] acc,
                                             input logic [15:0] data);
    logic [15:0] c;
    logic        fb;
    c = acc;
    for (int i = 15; i >= 0; i--) begin
      fb = c[15] ^ data[i];
      c  = {c[14:0], 1'b0} ^ (fb ? scg_pkg::MAP_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // Front gain code to linear gain 2, 4, 8 or 16.
  function automatic logic [4:0] front_mult(input logic [1:0] code);
    case (code)
      2'b00:   front_mult = 5'h02;
      2'b01:   front_mult = 5'h04;
      2'b10:   front_mult = 5'h08;
      default: front_mult = 5'h10;
    endcase
  endfunction

  // Variable gain code to gain in tenths: 14, 28, 56 or 112.
  function automatic logic [6:0] variable_tenths(input logic [1:0] code);
    case (code)
      2'b00:   variable_tenths = 7'h0E;
      2'b01:   variable_tenths = 7'h1C;
      2'b10:   variable_tenths = 7'h38;
      default: variable_tenths = 7'h70;
    endcase
  endfunction

  // Applies the two low byte strobes to a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (wd[15:0] & m);
  endfunction

  // -------------------------------------------------------------------------
  // State.
  // -------------------------------------------------------------------------
  logic [15:0]            clear_r;
  logic [15:0]            mask_r;
  logic [5:0]             err_r;
  logic [5:0]             err_nxt;
  logic [15:0]            crc_val_r;
  logic [15:0]            start_r;
  logic [15:0]            map_acc_r;
  logic [15:0]            map_acc_nxt;
  logic [15:0]            map_res_r;
  logic                   done_r;
  logic [2:0]             word_r;
  scg_pkg::scg_state_type state_r;
  scg_pkg::scg_state_type state_nxt;
  logic [7:0]             front_r;
  logic [7:0]             variable_r;
  logic [19:0]            front_mult_r;
  logic [27:0]            variable_tenths_r;
  logic [31:0]            prdata_r;

  // -------------------------------------------------------------------------
  // Bus decode.
  // -------------------------------------------------------------------------
  wire [9:0]  idx        = paddr[11:2];
  wire        aligned    = (paddr[1:0] == 2'b00);
  wire        hit_clear  = aligned && (idx == scg_pkg::IDX_SAFETY_FAULT_CLEAR);
  wire        hit_mask   = aligned && (idx == scg_pkg::IDX_SAFETY_FAULT_MASK);
  wire        hit_sum    = aligned && (idx == scg_pkg::IDX_SAFETY_FAULT_SUMMARY);
  wire        hit_err    = aligned && (idx == scg_pkg::IDX_SAFETY_ERROR_CODE);
  wire        hit_crcl   = aligned && (idx == scg_pkg::IDX_CRC_RESULT_LOW);
  wire        hit_crch   = aligned && (idx == scg_pkg::IDX_CRC_RESULT_HIGH);
  wire        hit_start  = aligned && (idx == scg_pkg::IDX_MAP_CHECK_START);
  wire        hit_done   = aligned && (idx == scg_pkg::IDX_MAP_CHECK_DONE);
  wire        hit_mapl   = aligned && (idx == scg_pkg::IDX_MAP_CHECK_LOW);
  wire        hit_maph   = aligned && (idx == scg_pkg::IDX_MAP_CHECK_HIGH);
  wire        hit_front  = aligned && (idx == scg_pkg::IDX_FRONT_AMP_GAIN);
  wire        hit_var    = aligned && (idx == scg_pkg::IDX_VARIABLE_AMP_GAIN);
  wire        mapped     = hit_clear | hit_mask | hit_sum | hit_err | hit_crcl |
                           hit_crch | hit_start | hit_done | hit_mapl | hit_maph |
                           hit_front | hit_var;
  wire        setup      = psel && !penable;
  wire        wr_access  = psel && penable && pwrite && mapped;

  // Every register answers at once; unmapped addresses report an error.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // -------------------------------------------------------------------------
  // Safety error capture.
  // -------------------------------------------------------------------------
  wire [5:0] fault_raw = {clock_loss_fault, neg_bias_fault, pos_bias_fault,
                          reference_fault, hot_fault, crc_error_fault};

  // A held clear blocks all reporting; otherwise unmasked faults stick.
  assign err_nxt = clear_r[0] ? scg_pkg::RST_ERR
                              : (err_r | (fault_raw & ~mask_r[5:0]));

  // Summary reflects any latched error that is not masked now.
  wire summary = |(err_r & ~mask_r[5:0]);

  // -------------------------------------------------------------------------
  // Register map check engine.
  // -------------------------------------------------------------------------
  wire start_req = wr_access && hit_start && pwdata[0] && pstrb[0] &&
                   (state_r == scg_pkg::SCG_IDLE);

  // Covered words in order: clear, mask, front gain, variable gain.
  wire [15:0] cover_word = (word_r == 3'h0) ? clear_r :
                           (word_r == 3'h1) ? mask_r :
                           (word_r == 3'h2) ? {8'h00, front_r} :
                                              {8'h00, variable_r};

  wire last_word = (word_r == scg_pkg::MAP_CRC_WORDS - 3'h1);

  assign map_acc_nxt = crc16_word(map_acc_r, cover_word);

  // Engine sequencing: idle, fold one word per cycle, latch result.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      scg_pkg::SCG_IDLE: begin
        if (start_req) begin
          state_nxt = scg_pkg::SCG_RUN;
        end
      end
      scg_pkg::SCG_RUN: begin
        if (last_word) begin
          state_nxt = scg_pkg::SCG_LATCH;
        end
      end
      scg_pkg::SCG_LATCH: begin
        state_nxt = scg_pkg::SCG_IDLE;
      end
      default: begin
        state_nxt = scg_pkg::SCG_IDLE;
      end
    endcase
  end

  // Engine registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= scg_pkg::SCG_IDLE;
      map_acc_r <= scg_pkg::MAP_CRC_SEED;
      word_r    <= 3'h0;
      map_res_r <= scg_pkg::RST_REG16;
      done_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (start_req) begin
        map_acc_r <= scg_pkg::MAP_CRC_SEED;
        word_r    <= 3'h0;
        done_r    <= 1'b0;
      end else if (state_r == scg_pkg::SCG_RUN) begin
        map_acc_r <= map_acc_nxt;
        word_r    <= word_r + 3'h1;
      end else if (state_r == scg_pkg::SCG_LATCH) begin
        map_res_r <= map_acc_r;
        done_r    <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Software registers and status capture.
  // -------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_r   <= scg_pkg::RST_REG16;
      mask_r    <= scg_pkg::RST_REG16;
      start_r   <= scg_pkg::RST_REG16;
      front_r   <= scg_pkg::RST_GAIN;
      variable_r <= scg_pkg::RST_GAIN;
      err_r     <= scg_pkg::RST_ERR;
      crc_val_r <= scg_pkg::RST_REG16;
    end else begin
      err_r     <= err_nxt;
      crc_val_r <= crc_value_in;
      if (wr_access && hit_clear) begin
        clear_r <= merge16(clear_r, pwdata, pstrb) & 16'h0001;
      end
      if (wr_access && hit_mask) begin
        mask_r <= merge16(mask_r, pwdata, pstrb) & 16'h003F;
      end
      if (wr_access && hit_start) begin
        start_r <= merge16(start_r, pwdata, pstrb) & 16'h0001;
      end
      if (wr_access && hit_front && pstrb[0]) begin
        front_r <= pwdata[7:0];
      end
      if (wr_access && hit_var && pstrb[0]) begin
        variable_r <= pwdata[7:0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Gain decoding per channel, channel 1 in the low field.
  // -------------------------------------------------------------------------
  wire [19:0] front_dec = {front_mult(front_r[7:6]), front_mult(front_r[5:4]),
                           front_mult(front_r[3:2]), front_mult(front_r[1:0])};
  wire [27:0] var_dec   = {variable_tenths(variable_r[7:6]),
                           variable_tenths(variable_r[5:4]),
                           variable_tenths(variable_r[3:2]),
                           variable_tenths(variable_r[1:0])};

  // Decoded gains are registered so the analog side sees clean levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      front_mult_r      <= 20'h0_0000;
      variable_tenths_r <= 28'h000_0000;
    end else begin
      front_mult_r      <= front_dec;
      variable_tenths_r <= var_dec;
    end
  end

  // -------------------------------------------------------------------------
  // Read data, captured in the setup phase and held through the access.
  // -------------------------------------------------------------------------
  wire [15:0] rd_word =
    hit_clear ? clear_r :
    hit_mask  ? mask_r :
    hit_sum   ? {15'h0000, summary} :
    hit_err   ? {10'h000, err_r} :
    hit_crcl  ? {8'h00, crc_val_r[7:0]} :
    hit_crch  ? {8'h00, crc_val_r[15:8]} :
    hit_start ? start_r :
    hit_done  ? {15'h0000, done_r} :
    hit_mapl  ? {8'h00, map_res_r[7:0]} :
    hit_maph  ? {8'h00, map_res_r[15:8]} :
    hit_front ? {8'h00, front_r} :
    hit_var   ? {8'h00, variable_r} :
                16'h0000;

  // Read data register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= {16'h0000, rd_word};
    end
  end

  // -------------------------------------------------------------------------
  // Outputs.
  // -------------------------------------------------------------------------
  assign prdata                   = prdata_r;
  assign safety_fault_summary     = summary;
  assign map_check_busy           = (state_r != scg_pkg::SCG_IDLE);
  assign map_check_done           = done_r;
  assign front_amp_gain           = front_r;
  assign front_amp_gain_mult      = front_mult_r;
  assign variable_amp_gain        = variable_r;
  assign variable_amp_gain_tenths = variable_tenths_r;

endmodule

// file: tb/scg_regs_properties.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Port checker of the register slice.
// ---------------------------------------------------------------------------
module scg_regs_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        safety_fault_summary,
  input wire logic        map_check_busy,
  input wire logic        map_check_done,
  input wire logic [7:0]  front_amp_gain,
  input wire logic [19:0] front_amp_gain_mult,
  input wire logic [7:0]  variable_amp_gain,
  input wire logic [27:0] variable_amp_gain_tenths
);
  // Access phase and a start request that an idle engine accepts.
  wire acc = psel && penable;
  wire go  = acc && pwrite && paddr == 12'h218 && pwdata[0] && pstrb[0] && !map_check_busy;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_zero_wait: assert property (acc |-> pready) else $error("pready low in access");
  a_bad_align: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access without error");
  a_good_addr: assert property (acc && paddr == 12'h400 |-> !pslverr)
    else $error("mapped access flagged");
  a_upper_zero: assert property (acc |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_done_after: assert property (go |=> !map_check_done [*5] ##1 map_check_done)
    else $error("done not on the sixth edge");
  a_busy_span: assert property (go |=> map_check_busy [*5] ##1 !map_check_busy)
    else $error("busy span wrong");
  a_done_holds: assert property (map_check_done && !go |=> map_check_done)
    else $error("done dropped without start");
  a_front_dec: assert property ($past(presetn) && $stable(front_amp_gain) |->
    front_amp_gain_mult == {5'h02 << front_amp_gain[7:6], 5'h02 << front_amp_gain[5:4],
    5'h02 << front_amp_gain[3:2], 5'h02 << front_amp_gain[1:0]})
    else $error("front gain decode wrong");
  a_var_dec: assert property ($past(presetn) && $stable(variable_amp_gain) |->
    variable_amp_gain_tenths == {7'h0e << variable_amp_gain[7:6],
    7'h0e << variable_amp_gain[5:4], 7'h0e << variable_amp_gain[3:2],
    7'h0e << variable_amp_gain[1:0]}) else $error("variable gain decode wrong");

  // Main scenarios reached.
  c_start: cover property (go);
  c_refuse: cover property (acc && pslverr);
  c_fault: cover property (safety_fault_summary);
endmodule

bind scg_regs scg_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .safety_fault_summary(safety_fault_summary), .map_check_busy(map_check_busy),
  .map_check_done(map_check_done), .front_amp_gain(front_amp_gain),
  .front_amp_gain_mult(front_amp_gain_mult), .variable_amp_gain(variable_amp_gain),
  .variable_amp_gain_tenths(variable_amp_gain_tenths));

// file: tb/safety_crc_gain_regs_bench.sv
`timescale 1ns/1ps
`define SCG_CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, got, exp); end end

module safety_crc_gain_regs_bench;
  // -------------------------------------------------------------------------
  // Stimulus, model and design.
  // -------------------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hf;
  logic [5:0]  flt = 6'h00;
  logic [15:0] crc_in = 16'h0000;
  logic [31:0] seed = 32'h0000_186e;
  logic [31:0] rdat;
  logic        rerr;
  wire  [31:0] prdata;
  wire         pready, pslverr, summ, busy, done;
  wire  [7:0]  fg, vg;
  wire  [19:0] fmul;
  wire  [27:0] vten;
  int          num_errors = 0;
  int          compares = 0;
  int          mdl[int];

  scg_regs u_scg_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clock_loss_fault(flt[5]), .neg_bias_fault(flt[4]),
    .pos_bias_fault(flt[3]), .reference_fault(flt[2]), .hot_fault(flt[1]),
    .crc_error_fault(flt[0]), .crc_value_in(crc_in), .safety_fault_summary(summ),
    .map_check_busy(busy), .map_check_done(done), .front_amp_gain(fg),
    .front_amp_gain_mult(fmul), .variable_amp_gain(vg), .variable_amp_gain_tenths(vten));

  // Clock at 50 MHz.
  always #10 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int ex(int i);
    return mdl.exists(i) ? mdl[i] : 0;
  endfunction

  // CRC-16 of the model's covered words, polynomial 1021, seed all ones, MSB first.
  function automatic logic [15:0] crc16();
    logic [15:0] c, w;
    int          q[$];
    c = 16'hffff;
    q = '{ex(10'h080), ex(10'h081), ex(10'h100), ex(10'h101)};
    foreach (q[k]) begin
      w = 16'(q[k]);
      for (int b = 15; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? 16'h1021 : 16'h0);
    end
    return c;
  endfunction

  // One APB transfer; request held until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write; the model keeps the writable bits only.
  task automatic wr(input int i, input int d);
    apb(1'b1, 12'(i * 4), 32'(d), 4'hf);
    case (i)
      10'h080, 10'h086: mdl[i] = d & 1;
      10'h081: mdl[i] = d & 32'h0000_003f;
      10'h100, 10'h101: mdl[i] = d & 32'h0000_00ff;
      default: ;
    endcase
  endtask

  task automatic chk_rd(input int i);
    apb(1'b0, 12'(i * 4), 32'h0000_0000, 4'hf);
    `SCG_CHK(rdat, 32'(ex(i)))
  endtask

  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog cutting a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    complete_run();
  end

  // Main sequence.
  initial begin
    int          idx[$];
    logic [7:0]  v, w;
    logic [19:0] em;
    logic [27:0] et;
    logic [15:0] c;
    idx = '{10'h080, 10'h081, 10'h082, 10'h083, 10'h084, 10'h085, 10'h086, 10'h087, 10'h088,
            10'h089, 10'h100, 10'h101};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (idx[k]) chk_rd(idx[k]);
    c = 16'(rnd());
    crc_in <= c;
    mdl[10'h084] = c[7:0];
    mdl[10'h085] = c[15:8];
    chk_rd(10'h084);
    chk_rd(10'h085);
    wr(10'h083, 32'h0000_003f);
    wr(10'h089, 32'h0000_00ff);
    chk_rd(10'h083);
    chk_rd(10'h089);
    for (int k = 0; k < 10; k++) begin
      v = (k < 4) ? 8'(k * 8'h55) : 8'(rnd());
      w = (k < 4) ? ~v : 8'(rnd());
      wr(10'h100, v);
      wr(10'h101, w);
      repeat (2) @(posedge pclk);
      for (int ch = 0; ch < 4; ch++) begin
        em[5 * ch +: 5] = 5'h02 << v[2 * ch +: 2];
        et[7 * ch +: 7] = 7'h0e << w[2 * ch +: 2];
      end
      `SCG_CHK(fmul, em)
      `SCG_CHK(vten, et)
      `SCG_CHK(fg, v)
      `SCG_CHK(vg, w)
      chk_rd(10'h100);
      chk_rd(10'h101);
    end
    apb(1'b1, 12'h400, 32'h0000_0000, 4'b0010);
    chk_rd(10'h100);
    for (int i = 0; i < 6; i++) begin
      flt <= 6'(1 << i);
      repeat (2) @(posedge pclk);
      flt <= 6'h00;
      mdl[10'h083] = 1 << i;
      mdl[10'h082] = 1;
      chk_rd(10'h083);
      chk_rd(10'h082);
      `SCG_CHK(summ, 1'b1)
      wr(10'h080, 1);
      wr(10'h080, 0);
      mdl[10'h083] = 0;
      mdl[10'h082] = 0;
      chk_rd(10'h083);
      `SCG_CHK(summ, 1'b0)
    end
    wr(10'h081, 32'h0000_003f);
    flt <= 6'h3f;
    repeat (2) @(posedge pclk);
    flt <= 6'h00;
    chk_rd(10'h083);
    `SCG_CHK(summ, 1'b0)
    wr(10'h081, 32'h0000_0000);
    wr(10'h080, 1);
    flt <= 6'h3f;
    repeat (2) @(posedge pclk);
    flt <= 6'h00;
    wr(10'h080, 0);
    chk_rd(10'h083);
    wr(10'h081, rnd());
    // A second start lands while the engine runs and must be ignored.
    wr(10'h086, 1);
    wr(10'h086, 1);
    `SCG_CHK(busy, 1'b1)
    chk_rd(10'h087);
    `SCG_CHK(done, 1'b1)
    while (done !== 1'b1) begin
      @(posedge pclk);
    end
    c = crc16();
    mdl[10'h087] = 1;
    mdl[10'h088] = c[7:0];
    mdl[10'h089] = c[15:8];
    chk_rd(10'h087);
    chk_rd(10'h088);
    chk_rd(10'h089);
    chk_rd(10'h086);
    wr(10'h086, 1);
    mdl[10'h087] = 0;
    chk_rd(10'h087);
    apb(1'b0, 12'h3fc, 32'h0000_0000, 4'hf);
    `SCG_CHK(rerr, 1'b1)
    apb(1'b1, 12'h401, 32'h0000_00ff, 4'hf);
    `SCG_CHK(rerr, 1'b1)
    chk_rd(10'h100);
    complete_run();
  end
endmodule
